// File: sim/secfg_host.sv
// Serial bus host model facing the configuration bank
`timescale 1ns/10ps
module secfg_host (
  // Bus lines
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam int Q = 80;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // ==========================================================
  // Frame conditions
  task automatic start_cond();
    if (scl == 1'b0)
    begin
      #(4 * Q) scl = 1'b1;
    end
    #(2 * Q) sda_low = 1'b1;
    #(2 * Q) scl = 1'b0;
  endtask : start_cond
  // Returns at the data rise so the caller sees the window before it closes
  task automatic stop_cond();
    #Q sda_low = 1'b1;
    #(3 * Q) scl = 1'b1;
    #(2 * Q) sda_low = 1'b0;
  endtask : stop_cond
  // ==========================================================
  // Bits and bytes, one 320 ns clock period per bit
  task automatic put_bit(input logic b, input int lo, output logic s);
    #Q sda_low = ~b;
    #(lo - Q) scl = 1'b1;
    #(2 * Q) s = sda;
    scl = 1'b0;
  endtask : put_bit
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], 2 * Q, s);
    put_bit(1'b1, 2 * Q, s);
    ack = ~s;
  endtask : wbyte
  task automatic rbyte(output logic [7:0] d, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(1'b1, 2 * Q, s);
      d[i] = s;
    end
    put_bit(last, 2 * Q, s);
  endtask : rbyte
endmodule : secfg_host

// File: sim/tb.sv
// Self-checking bench for the configuration bank
`timescale 1ns/10ps
module tb;
  localparam int STEP = 10;
  localparam int PER = 512;
  localparam logic [6:0] DEV = secfg_pkg::DEFAULT_DEV_ADDR;
  logic mclk = 1'b0;
  logic rst, scl, host_low, sda_out, sda_oe, pwm_en, pin, ite, nph, win;
  logic [7:0] ev_raw, ev_ok;
  logic [2:0] halt, quick, other, go;
  logic [7:0] wr [0:4];
  logic [7:0] rd [0:5];
  wire sda;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_close = 0;
  // Open drain with pull-up
  assign sda = ~(host_low | (sda_oe & ~sda_out));
  always @(negedge win) n_close++;
  initial
  begin
    forever #20 mclk = ~mclk;
  end
  secfg_top #(
    .STEP_CYCLES(STEP),
    .PWM_PERIOD(PER)
  ) i_secfg_top (
    .mclk(mclk), .rst(rst), .scl_pin(scl), .sda_pin(sda), .sda_level(sda_out), .sda_oe(sda_oe),
    .pwm_out_enable(pwm_en), .event_raw(ev_raw), .event_allowed(ev_ok),
    .halt_timeout_reseed(halt), .quick_release_reseed(quick), .other_reseed(other), .reseed_go(go),
    .pulse_output_pin(pin), .inductive_transmit_enable(ite), .normal_power_hold(nph),
    .comm_window_open(win)
  );
  secfg_host i_secfg_host (
    .scl(scl),
    .sda_low(host_low),
    .sda(sda)
  );
  // ==========================================================
  // Shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic reg_write(input logic [7:0] ptr, input int n);
    logic a;
    logic ok;
    i_secfg_host.start_cond();
    i_secfg_host.wbyte({DEV, 1'b0}, ok);
    i_secfg_host.wbyte(ptr, a);
    ok = ok & a;
    for (int i = 0; i < n; i++)
    begin
      i_secfg_host.wbyte(wr[i], a);
      ok = ok & a;
    end
    i_secfg_host.stop_cond();
    check(ok, 1'b1);
  endtask : reg_write
  task automatic reg_read(input logic [7:0] ptr, input int n);
    logic a;
    i_secfg_host.start_cond();
    i_secfg_host.wbyte({DEV, 1'b0}, a);
    i_secfg_host.wbyte(ptr, a);
    i_secfg_host.start_cond();
    i_secfg_host.wbyte({DEV, 1'b1}, a);
    for (int i = 0; i < n; i++)
      i_secfg_host.rbyte(rd[i], i == n - 1);
    i_secfg_host.stop_cond();
  endtask : reg_read
  task automatic wait_close(output int c);
    check(win, 1'b1);
    c = 0;
    while (win === 1'b1 && c < 200)
    begin
      @(posedge mclk);
      #1;
      c++;
    end
  endtask : wait_close
  // ==========================================================
  // Scenarios
  task automatic t_reset_values();
    check(ite, 1'b1);
    check(pin, 1'b0);
    reg_read(secfg_pkg::OFF_EVENT_MASK, 6);
    check(rd[0], 8'h00);
    check(rd[1], 8'h00);
    check(rd[2], 8'h20);
    check(rd[3], 8'h01);
    check(rd[4], 8'h07);
    check(rd[5], 8'h00);
  endtask : t_reset_values
  task automatic t_config_window();
    int c;
    int snap;
    wr[0] = 8'ha5;
    wr[1] = 8'h7f;
    wr[2] = 8'h03;
    wr[3] = 8'h81;
    wr[4] = 8'hfd;
    reg_write(secfg_pkg::OFF_EVENT_MASK, 5);
    wait_close(c);
    check(c >= 30 && c <= 42, 1'b1);
    reg_read(secfg_pkg::OFF_EVENT_MASK, 5);
    check(rd[0], 8'ha5);
    check(rd[1], 8'h7f);
    check(rd[2], 8'h03);
    check(rd[3], 8'h81);
    check(rd[4], 8'h05);
    repeat (15) @(posedge mclk);
    #1;
    snap = n_close;
    reg_read(secfg_pkg::OFF_READY_TIMEOUT, 1);
    check(n_close, snap);
    wait_close(c);
    check(c >= 30 && c <= 42, 1'b1);
  endtask : t_config_window
  task automatic t_stop_closes();
    int c;
    wr[0] = 8'h01;
    reg_write(secfg_pkg::OFF_BUS_SETTINGS, 1);
    wait_close(c);
    check(c <= 8, 1'b1);
  endtask : t_stop_closes
  task automatic t_event_mask();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      #1 ev_raw = 8'h01 << i;
      @(posedge mclk);
      #1 check(ev_ok, (8'h01 << i) & ~8'ha5);
    end
  endtask : t_event_mask
  task automatic reseed_case(input logic [2:0] h, q, o, exp);
    @(posedge mclk);
    #1;
    halt = h;
    quick = q;
    other = o;
    @(posedge mclk);
    #1 check(go, exp);
  endtask : reseed_case
  task automatic t_reseed_gate();
    reseed_case(3'h7, 3'h0, 3'h0, 3'h5);
    reseed_case(3'h0, 3'h7, 3'h0, 3'h5);
    reseed_case(3'h0, 3'h0, 3'h7, 3'h7);
    reseed_case(3'h2, 3'h2, 3'h0, 3'h0);
    reseed_case(3'h0, 3'h0, 3'h0, 3'h0);
  endtask : t_reseed_gate
  task automatic pwm_measure(output int hi, output int rises);
    logic prev;
    hi = 0;
    rises = 0;
    repeat (PER) @(posedge mclk);
    #1 prev = pin;
    repeat (PER)
    begin
      @(posedge mclk);
      #1;
      hi += (pin === 1'b1);
      rises += (pin === 1'b1 && prev === 1'b0);
      prev = pin;
    end
  endtask : pwm_measure
  task automatic t_pulse_output();
    int hi;
    int ri;
    logic [7:0] d;
    @(posedge mclk);
    #1 pwm_en = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      d = (k == 0) ? 8'h00 : (k == 1) ? 8'h7f : 8'hff;
      wr[0] = d;
      reg_write(secfg_pkg::OFF_PWM_DUTY, 1);
      pwm_measure(hi, ri);
      check(hi, (d + 1) * (PER / 256));
      check(ri, (d == 8'hff) ? 0 : 1);
    end
    check(ite, 1'b0);
    check(nph, 1'b1);
    @(posedge mclk);
    #1 pwm_en = 1'b0;
    pwm_measure(hi, ri);
    check(hi, 0);
    check(ite, 1'b1);
    check(nph, 1'b0);
  endtask : t_pulse_output
  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    rst = 1'b1;
    pwm_en = 1'b0;
    ev_raw = 8'h00;
    halt = 3'h0;
    quick = 3'h0;
    other = 3'h0;
    repeat (6) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    t_reset_values();
    t_config_window();
    t_stop_closes();
    t_event_mask();
    t_reseed_gate();
    t_pulse_output();
    final_report();
  end
  initial
  begin
    #1000000;
    n_mismatch++;
    final_report();
  end
endmodule : tb

// File: verilog/secfg_pkg.sv
// Constants for the sensor event, pulse output and bus window configuration bank
package secfg_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_EVENT_MASK = 8'hd7;
  localparam logic [7:0] OFF_PWM_DUTY = 8'hd8;
  localparam logic [7:0] OFF_READY_TIMEOUT = 8'hd9;
  localparam logic [7:0] OFF_BUS_SETTINGS = 8'hda;
  localparam logic [7:0] OFF_RESEED_EN = 8'hdb;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_EVENT_MASK = 8'h00;
  localparam logic [7:0] RST_PWM_DUTY = 8'h00;
  localparam logic [7:0] RST_READY_TIMEOUT = 8'h20;
  localparam logic [7:0] RST_BUS_SETTINGS = 8'h01;
  localparam logic [2:0] RST_RESEED_EN = 3'h7;
  // ==========================================================
  // Field positions
  localparam int STOP_IGNORE_BIT = 7;
  localparam int BUS_FIXED_BIT = 0;
  localparam int RESEED_WIDTH = 3;
  localparam int EVENT_WIDTH = 8;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TIMEOUT_STEP_NS = 320000;
  localparam int PWM_PERIOD_NS = 1000000;
  localparam int TIMEOUT_STEP_CYCLES = TIMEOUT_STEP_NS / CLK_PERIOD_NS;
  localparam int PWM_PERIOD_CYCLES = PWM_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PWM_STEPS = 256;
  // ==========================================================
  // Bus address, value arbitrary
  localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h2a;
  // ==========================================================
  // Serial engine states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK = 6'h04,
    ST_WRITE = 6'h08,
    ST_READ = 6'h10,
    ST_RACK = 6'h20
  } secfg_state_t;
endpackage : secfg_pkg

// File: verilog/secfg_pwm.sv
// Fixed-rate pulse width generator for the dedicated output pin
`timescale 1ns/10ps
module secfg_pwm #(
  parameter int PERIOD_CYCLES = secfg_pkg::PWM_PERIOD_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic [7:0] duty,
  // Pin
  output logic pulse
);
  // ==========================================================
  // Fractional prescaler: 256 steps per period exactly
  logic [16:0] acc;
  logic [7:0] step;
  wire [16:0] acc_sum = acc + 17'(secfg_pkg::PWM_STEPS);
  wire acc_wrap = acc_sum >= 17'(PERIOD_CYCLES);
  wire [16:0] next_acc = acc_wrap ? acc_sum - 17'(PERIOD_CYCLES) : acc_sum;
  wire next_pwm = enable && (step <= duty);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      acc <= 17'h00000;
      step <= 8'h00;
      pulse <= 1'b0;
    end
    else
    begin
      acc <= next_acc;
      step <= acc_wrap ? step + 8'h01 : step;
      pulse <= next_pwm;
    end
  end

  // ==========================================================
  // Checks
  property p_pwm_level;
    @(posedge mclk) disable iff (rst) 1'b1 |=> pulse == $past(enable && (step <= duty));
  endproperty
  a_pwm_level: assert property (p_pwm_level) else $error("pulse level not set by step versus duty");
  property p_pwm_off;
    @(posedge mclk) disable iff (rst) !enable |=> !pulse;
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pulse driven while disabled");
  property p_pwm_acc;
    @(posedge mclk) disable iff (rst) acc < 17'(PERIOD_CYCLES);
  endproperty
  a_pwm_acc: assert property (p_pwm_acc) else $error("prescaler out of range");
  property p_pwm_step;
    @(posedge mclk) disable iff (rst) acc_wrap |=> step == $past(step) + 8'h01;
  endproperty
  a_pwm_step: assert property (p_pwm_step) else $error("step did not advance on wrap");
  c_pwm_wrap: cover property (@(posedge mclk) disable iff (rst) enable && acc_wrap && step == 8'hff);
endmodule : secfg_pwm

// File: verilog/secfg_timer.sv
// Ready timeout counter for the bus window
`timescale 1ns/10ps
module secfg_timer #(
  parameter int STEP_CYCLES = secfg_pkg::TIMEOUT_STEP_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic cancel,
  input wire logic [7:0] steps,
  // Status
  output logic expired
);
  logic running;
  logic [7:0] left;
  logic [15:0] pre;
  wire pre_end = pre == 16'(STEP_CYCLES - 1);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      running <= 1'b0;
      left <= 8'h00;
      pre <= 16'h0000;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (cancel)
        running <= 1'b0;
      else if (load)
      begin
        running <= 1'b1;
        left <= steps;
        pre <= 16'h0000;
      end
      else if (running && left == 8'h00)
      begin
        running <= 1'b0;
        expired <= 1'b1;
      end
      else if (running)
      begin
        pre <= pre_end ? 16'h0000 : pre + 16'h0001;
        left <= pre_end ? left - 8'h01 : left;
      end
    end
  end

  property p_tmr_expire;
    @(posedge mclk) disable iff (rst) expired |-> $past(running) && $past(left) == 8'h00;
  endproperty
  a_tmr_expire: assert property (p_tmr_expire) else $error("timeout fired early");
endmodule : secfg_timer

// File: verilog/secfg_top.sv
// Configuration bank reached over the serial bus: event mask, pulse output, window and reseed control
`timescale 1ns/10ps
// Notes on behaviour
// - Event mask: one bit per source, 1 masks, 0 allows, resets to zero.
// - Pulse duty equals (duty value plus one) over 256.
// - Pulse runs at fixed 1 kHz on the dedicated output pin.
// - Pulse is produced only while the external enable bit is set.
// - Ready timeout equals value times 0.32 ms, resets to 32 steps.
// - With stop-ignore clear, a stop closes the window.
// - With stop-ignore set, window closes only when no start within the timeout.
// - Reseed bits 2 to 0 enable auto reseed per channel, all set at reset.
// - Reseed bits gate only halt-timeout and quick-release auto reseeds.
// - While pulse is on, inductive transmit is off and normal power held.
module secfg_top #(
  parameter logic [6:0] DEV_ADDR = secfg_pkg::DEFAULT_DEV_ADDR,
  parameter int STEP_CYCLES = secfg_pkg::TIMEOUT_STEP_CYCLES,
  parameter int PWM_PERIOD = secfg_pkg::PWM_PERIOD_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Serial bus pins
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_level,
  output logic sda_oe,
  // Power mode settings
  input wire logic pwm_out_enable,
  // Event sources
  input wire logic [7:0] event_raw,
  output logic [7:0] event_allowed,
  // Reseed requests
  input wire logic [2:0] halt_timeout_reseed,
  input wire logic [2:0] quick_release_reseed,
  input wire logic [2:0] other_reseed,
  output logic [2:0] reseed_go,
  // Pins and status
  output logic pulse_output_pin,
  output logic inductive_transmit_enable,
  output logic normal_power_hold,
  output logic comm_window_open
);
  // ==========================================================
  // Registers
  logic [7:0] event_source_mask;
  logic [7:0] pwm_duty_setting;
  logic [7:0] ready_timeout_period;
  logic stop_ignore;
  logic bus_fixed;
  logic [2:0] channel_reseed_enables;
  // ==========================================================
  // Pin synchronisers
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_m <= scl_pin;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_pin;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire bus_start = scl_s && scl_d && sda_d && !sda_s;
  wire bus_stop = scl_s && scl_d && !sda_d && sda_s;
  // ==========================================================
  // Serial engine
  secfg_pkg::secfg_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] ptr;
  logic have_ptr;
  logic rd_mode;
  logic master_ack;
  wire [7:0] rd_data =
    (ptr == secfg_pkg::OFF_EVENT_MASK) ? event_source_mask :
    (ptr == secfg_pkg::OFF_PWM_DUTY) ? pwm_duty_setting :
    (ptr == secfg_pkg::OFF_READY_TIMEOUT) ? ready_timeout_period :
    (ptr == secfg_pkg::OFF_BUS_SETTINGS) ? {stop_ignore, 6'h00, bus_fixed} :
    (ptr == secfg_pkg::OFF_RESEED_EN) ? {5'h00, channel_reseed_enables} :
    8'h00;
  wire byte_end = scl_fall && (bitcnt == 4'h8);
  wire addr_hit = shreg[7:1] == DEV_ADDR;
  wire addr_done = (state == secfg_pkg::ST_ADDR) && byte_end;
  wire wbyte_done = (state == secfg_pkg::ST_WRITE) && byte_end;
  wire reg_write = wbyte_done && have_ptr;
  wire ack_end = (state == secfg_pkg::ST_ACK) && scl_fall;
  wire load_read = (ack_end && rd_mode) || ((state == secfg_pkg::ST_RACK) && scl_fall && master_ack);
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state <= secfg_pkg::ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      have_ptr <= 1'b0;
      rd_mode <= 1'b0;
      master_ack <= 1'b0;
      sda_oe <= 1'b0;
      sda_level <= 1'b0;
    end
    else if (bus_start)
    begin
      state <= secfg_pkg::ST_ADDR;
      bitcnt <= 4'h0;
      have_ptr <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (bus_stop)
    begin
      state <= secfg_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end
    else
    begin
      case (state)
        secfg_pkg::ST_IDLE:
          sda_oe <= 1'b0;
        secfg_pkg::ST_ADDR, secfg_pkg::ST_WRITE:
        begin
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end
          else if (byte_end)
          begin
            bitcnt <= 4'h0;
            if (state == secfg_pkg::ST_ADDR)
            begin
              rd_mode <= shreg[0];
              state <= addr_hit ? secfg_pkg::ST_ACK : secfg_pkg::ST_IDLE;
              sda_oe <= addr_hit;
            end
            else
            begin
              ptr <= have_ptr ? ptr + 8'h01 : shreg;
              have_ptr <= 1'b1;
              state <= secfg_pkg::ST_ACK;
              sda_oe <= 1'b1;
            end
          end
        end
        secfg_pkg::ST_ACK:
        begin
          if (ack_end)
          begin
            state <= rd_mode ? secfg_pkg::ST_READ : secfg_pkg::ST_WRITE;
            shreg <= rd_data;
            sda_oe <= rd_mode && !rd_data[7];
          end
        end
        secfg_pkg::ST_READ:
        begin
          if (scl_rise)
            bitcnt <= bitcnt + 4'h1;
          else if (byte_end)
          begin
            bitcnt <= 4'h0;
            sda_oe <= 1'b0;
            ptr <= ptr + 8'h01;
            state <= secfg_pkg::ST_RACK;
          end
          else if (scl_fall)
          begin
            shreg <= {shreg[6:0], 1'b0};
            sda_oe <= !shreg[6];
          end
        end
        secfg_pkg::ST_RACK:
        begin
          if (scl_rise)
            master_ack <= !sda_s;
          else if (load_read)
          begin
            state <= secfg_pkg::ST_READ;
            shreg <= rd_data;
            sda_oe <= !rd_data[7];
          end
          else if (scl_fall)
            state <= secfg_pkg::ST_IDLE;
        end
        default:
          state <= secfg_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Register file
  wire [7:0] wdata = shreg;
  wire wr_mask = reg_write && ptr == secfg_pkg::OFF_EVENT_MASK;
  wire wr_duty = reg_write && ptr == secfg_pkg::OFF_PWM_DUTY;
  wire wr_tmo = reg_write && ptr == secfg_pkg::OFF_READY_TIMEOUT;
  wire wr_bus = reg_write && ptr == secfg_pkg::OFF_BUS_SETTINGS;
  wire wr_reseed = reg_write && ptr == secfg_pkg::OFF_RESEED_EN;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      event_source_mask <= secfg_pkg::RST_EVENT_MASK;
      pwm_duty_setting <= secfg_pkg::RST_PWM_DUTY;
      ready_timeout_period <= secfg_pkg::RST_READY_TIMEOUT;
      stop_ignore <= secfg_pkg::RST_BUS_SETTINGS[secfg_pkg::STOP_IGNORE_BIT];
      bus_fixed <= secfg_pkg::RST_BUS_SETTINGS[secfg_pkg::BUS_FIXED_BIT];
      channel_reseed_enables <= secfg_pkg::RST_RESEED_EN;
    end
    else
    begin
      if (wr_mask)
        event_source_mask <= wdata;
      if (wr_duty)
        pwm_duty_setting <= wdata;
      if (wr_tmo)
        ready_timeout_period <= wdata;
      if (wr_bus)
      begin
        stop_ignore <= wdata[secfg_pkg::STOP_IGNORE_BIT];
        bus_fixed <= wdata[secfg_pkg::BUS_FIXED_BIT];
      end
      if (wr_reseed)
        channel_reseed_enables <= wdata[secfg_pkg::RESEED_WIDTH-1:0];
    end
  end

  // ==========================================================
  // Communication window
  wire tmo_expired;
  wire stop_close = bus_stop && !stop_ignore && comm_window_open;
  wire stop_arm = bus_stop && stop_ignore && comm_window_open;
  secfg_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .mclk(mclk),
    .rst(rst),
    .load(stop_arm),
    .cancel(bus_start || stop_close),
    .steps(ready_timeout_period),
    .expired(tmo_expired)
  );

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      comm_window_open <= 1'b0;
    else if (addr_done && addr_hit)
      comm_window_open <= 1'b1;
    else if (stop_close || tmo_expired)
      comm_window_open <= 1'b0;
  end

  // ==========================================================
  // Events, reseeds and pulse output
  wire [7:0] next_event_allowed = event_raw & ~event_source_mask;
  wire [2:0] auto_reseed = halt_timeout_reseed | quick_release_reseed;
  wire [2:0] next_reseed_go = (auto_reseed & channel_reseed_enables) | other_reseed;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      event_allowed <= 8'h00;
      reseed_go <= 3'h0;
      inductive_transmit_enable <= 1'b1;
      normal_power_hold <= 1'b0;
    end
    else
    begin
      event_allowed <= next_event_allowed;
      reseed_go <= next_reseed_go;
      inductive_transmit_enable <= !pwm_out_enable;
      normal_power_hold <= pwm_out_enable;
    end
  end

  secfg_pwm #(
    .PERIOD_CYCLES(PWM_PERIOD)
  ) u_pwm (
    .mclk(mclk),
    .rst(rst),
    .enable(pwm_out_enable),
    .duty(pwm_duty_setting),
    .pulse(pulse_output_pin)
  );

  // ==========================================================
  // Checks
  property p_event_gate;
    @(posedge mclk) disable iff (rst) 1'b1 |=> event_allowed == ($past(event_raw) & ~$past(event_source_mask));
  endproperty
  a_event_gate: assert property (p_event_gate) else $error("event mask not applied");
  property p_stop_close;
    @(posedge mclk) disable iff (rst) stop_close |=> !comm_window_open;
  endproperty
  a_stop_close: assert property (p_stop_close) else $error("stop did not close window");
  property p_stop_hold;
    @(posedge mclk) disable iff (rst) (stop_arm && ready_timeout_period != 8'h00) |=> comm_window_open;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("ignored stop closed window");
  property p_close_cause;
    @(posedge mclk) disable iff (rst) $fell(comm_window_open) |-> $past(stop_close) || $past(tmo_expired);
  endproperty
  a_close_cause: assert property (p_close_cause) else $error("window closed without cause");
  property p_reseed;
    @(posedge mclk) disable iff (rst)
      1'b1 |=> reseed_go == (($past(auto_reseed) & $past(channel_reseed_enables)) | $past(other_reseed));
  endproperty
  a_reseed: assert property (p_reseed) else $error("reseed gating wrong");
  property p_itx_off;
    @(posedge mclk) disable iff (rst) pwm_out_enable |=> !inductive_transmit_enable && normal_power_hold;
  endproperty
  a_itx_off: assert property (p_itx_off) else $error("transmit not disabled under pulse output");
  property p_reseed_rst;
    @(posedge mclk) $fell(rst) |-> channel_reseed_enables == secfg_pkg::RST_RESEED_EN;
  endproperty
  a_reseed_rst: assert property (p_reseed_rst) else $error("reseed enables not set at reset");
  c_open: cover property (@(posedge mclk) disable iff (rst) $rose(comm_window_open));
  c_tmo: cover property (@(posedge mclk) disable iff (rst) tmo_expired);
  c_write: cover property (@(posedge mclk) disable iff (rst) wr_duty);
  c_read: cover property (@(posedge mclk) disable iff (rst) load_read);
endmodule : secfg_top
